/* File: port_ef_data.sv */
/*
 * Data latches, direction and pin-assign registers of two 8-bit discrete
 * I/O ports, reached over AXI4-Lite. Pins are split into in/out/enable.
 * Assumes pins are asynchronous; alternate functions live outside.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module port_ef_data #(
    parameter bit BIT3_PRESENT = 1'b1, // Optional first-port bit3 bonded out
    parameter bit BIT3_READ_VALUE = 1'b0 // Value read when bit3 absent
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [port_ef_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [port_ef_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [port_ef_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [port_ef_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [port_ef_pkg::PORT_W-1:0] first_port_in,
    output logic [port_ef_pkg::PORT_W-1:0] first_port_out,
    output logic [port_ef_pkg::PORT_W-1:0] first_port_oe,
    input wire logic [port_ef_pkg::PORT_W-1:0] second_port_in,
    output logic [port_ef_pkg::PORT_W-1:0] second_port_out,
    output logic [port_ef_pkg::PORT_W-1:0] second_port_oe,
    output logic [port_ef_pkg::PORT_W-1:0] first_port_pin_assign,
    output logic [port_ef_pkg::PORT_W-1:0] second_port_pin_assign
);
    import port_ef_pkg::*;

    // Storage
    logic [PORT_W-1:0] first_port_data_q; // Output latch, never reset
    logic [PORT_W-1:0] second_port_data_q; // Output latch, never reset
    logic [PORT_W-1:0] first_port_direction_q; // One = output
    logic [PORT_W-1:0] second_port_direction_q; // One = output
    logic [PORT_W-1:0] first_assign_q; // One = alternate function
    logic [PORT_W-1:0] second_assign_q; // One = alternate function

    // Bus holding registers
    logic aw_held_q; // Write address captured
    logic w_held_q; // Write data captured
    logic [ADDR_W-1:0] awaddr_q; // Captured write address
    logic [PORT_W-1:0] wdata_q; // Captured low byte of write data
    logic wlane_q; // Low byte lane enabled
    logic bvalid_q; // Write response pending
    logic [1:0] bresp_q; // Write response code
    logic rvalid_q; // Read response pending
    logic [1:0] rresp_q; // Read response code
    logic [DATA_W-1:0] rdata_q; // Read data

    // Synchronised pin levels
    logic [PORT_W-1:0] first_pin_sync;
    logic [PORT_W-1:0] second_pin_sync;

    pin_sync u_first_sync (
        .aclk(aclk),
        .async_in(first_port_in),
        .sync_out(first_pin_sync)
    );

    pin_sync u_second_sync (
        .aclk(aclk),
        .async_in(second_port_in),
        .sync_out(second_pin_sync)
    );

    // Handshake outputs
    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready = !w_held_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // Write commits once both halves are held and no response is pending
    wire wr_fire = aw_held_q && w_held_q && !bvalid_q;
    wire wr_en = wr_fire && wlane_q;
    // Both aliases reach the same latch
    wire wsel_e_data = (awaddr_q == ADDR_E_DATA0) || (awaddr_q == ADDR_E_DATA1);
    wire wsel_f_data = (awaddr_q == ADDR_F_DATA0) || (awaddr_q == ADDR_F_DATA1);
    wire wsel_e_dir = awaddr_q == ADDR_E_DIR;
    wire wsel_f_dir = awaddr_q == ADDR_F_DIR;
    wire wsel_e_asg = awaddr_q == ADDR_E_ASSIGN;
    wire wsel_f_asg = awaddr_q == ADDR_F_ASSIGN;
    wire wr_mapped = wsel_e_data || wsel_f_data || wsel_e_dir || wsel_f_dir || wsel_e_asg || wsel_f_asg;

    // Read decode
    wire rd_fire = s_axi_arvalid && !rvalid_q;
    wire rsel_e_data = (s_axi_araddr == ADDR_E_DATA0) || (s_axi_araddr == ADDR_E_DATA1);
    wire rsel_f_data = (s_axi_araddr == ADDR_F_DATA0) || (s_axi_araddr == ADDR_F_DATA1);
    wire rsel_e_dir = s_axi_araddr == ADDR_E_DIR;
    wire rsel_f_dir = s_axi_araddr == ADDR_F_DIR;
    wire rsel_e_asg = s_axi_araddr == ADDR_E_ASSIGN;
    wire rsel_f_asg = s_axi_araddr == ADDR_F_ASSIGN;
    wire rd_mapped = rsel_e_data || rsel_f_data || rsel_e_dir || rsel_f_dir || rsel_e_asg || rsel_f_asg;

    // A pin is a discrete input when given to I/O and direction is zero
    wire [PORT_W-1:0] first_is_input = ~first_assign_q & ~first_port_direction_q;
    wire [PORT_W-1:0] second_is_input = ~second_assign_q & ~second_port_direction_q;

    // Read-back value per bit: live pin for inputs, latch otherwise, BIT3_READ_VALUE for an absent first-port bit3
    logic [PORT_W-1:0] first_read;
    logic [PORT_W-1:0] second_read;
    for (genvar i = 0; i < PORT_W; i++) begin : g_read
        if (i == BIT3_POS && !BIT3_PRESENT) begin : g_absent
            assign first_read[i] = BIT3_READ_VALUE;
        end else begin : g_present
            assign first_read[i] = first_is_input[i] ? first_pin_sync[i] : first_port_data_q[i];
        end
        assign second_read[i] = second_is_input[i] ? second_pin_sync[i] : second_port_data_q[i];
    end

    // Low byte of the selected register; upper bits read zero
    wire [PORT_W-1:0] rd_byte =
        rsel_e_data ? first_read :
        rsel_f_data ? second_read :
        rsel_e_dir ? first_port_direction_q :
        rsel_f_dir ? second_port_direction_q :
        rsel_e_asg ? first_assign_q :
        rsel_f_asg ? second_assign_q : '0;
    wire [DATA_W-1:0] rd_word = {{(DATA_W-PORT_W){1'b0}}, rd_byte};

    // Write mask: absent bit3 keeps whatever it held
    wire [PORT_W-1:0] first_wmask = BIT3_PRESENT ? {PORT_W{1'b1}} : ~(PORT_W'(1) << BIT3_POS);

    // Pins driven only when given to I/O and set as output
    assign first_port_oe = ~first_assign_q & first_port_direction_q & first_wmask;
    assign second_port_oe = ~second_assign_q & second_port_direction_q;
    assign first_port_out = first_port_data_q;
    assign second_port_out = second_port_data_q;
    assign first_port_pin_assign = first_assign_q;
    assign second_port_pin_assign = second_assign_q;

    // Data latches: no reset, written when addressed with the low byte lane enabled
    always_ff @(posedge aclk) begin
        if (wr_en && wsel_e_data) begin
            first_port_data_q <= (wdata_q & first_wmask)
                | (first_port_data_q & ~first_wmask);
        end
        if (wr_en && wsel_f_data) begin
            second_port_data_q <= wdata_q;
        end
    end

    // Direction and pin-assign registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_port_direction_q <= DIR_RESET;
            second_port_direction_q <= DIR_RESET;
            first_assign_q <= ASSIGN_RESET;
            second_assign_q <= ASSIGN_RESET;
        end else begin
            if (wr_en && wsel_e_dir) begin
                first_port_direction_q <= wdata_q;
            end
            if (wr_en && wsel_f_dir) begin
                second_port_direction_q <= wdata_q;
            end
            if (wr_en && wsel_e_asg) begin
                first_assign_q <= wdata_q;
            end
            if (wr_en && wsel_f_asg) begin
                second_assign_q <= wdata_q;
            end
        end
    end

    // Write address and data capture, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wlane_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && !w_held_q) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata[PORT_W-1:0];
                wlane_q <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read response, data captured with the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= '0;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule

/* File: port_ef_pkg.sv */
/*
 * Constants for the two 8-bit discrete I/O data ports: register indices,
 * byte addresses on the register bus, field widths and reset values.
 * Assumes a 32-bit AXI4-Lite register bus with byte addressing.
 */
package port_ef_pkg;
    // Port and bus widths
    localparam int PORT_W = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register indices as printed; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_E_DATA0 = 8'h10;
    localparam logic [ADDR_W-1:0] IDX_E_DATA1 = 8'h12;
    localparam logic [ADDR_W-1:0] IDX_E_DIR = 8'h14;
    localparam logic [ADDR_W-1:0] IDX_E_ASSIGN = 8'h16;
    localparam logic [ADDR_W-1:0] IDX_F_DATA0 = 8'h18;
    localparam logic [ADDR_W-1:0] IDX_F_DATA1 = 8'h1a;
    localparam logic [ADDR_W-1:0] IDX_F_DIR = 8'h1c;
    localparam logic [ADDR_W-1:0] IDX_F_ASSIGN = 8'h1e;
    // Byte addresses derived from the indices
    localparam logic [ADDR_W-1:0] ADDR_E_DATA0 = ADDR_W'(IDX_E_DATA0 * 4);
    localparam logic [ADDR_W-1:0] ADDR_E_DATA1 = ADDR_W'(IDX_E_DATA1 * 4);
    localparam logic [ADDR_W-1:0] ADDR_E_DIR = ADDR_W'(IDX_E_DIR * 4);
    localparam logic [ADDR_W-1:0] ADDR_E_ASSIGN = ADDR_W'(IDX_E_ASSIGN * 4);
    localparam logic [ADDR_W-1:0] ADDR_F_DATA0 = ADDR_W'(IDX_F_DATA0 * 4);
    localparam logic [ADDR_W-1:0] ADDR_F_DATA1 = ADDR_W'(IDX_F_DATA1 * 4);
    localparam logic [ADDR_W-1:0] ADDR_F_DIR = ADDR_W'(IDX_F_DIR * 4);
    localparam logic [ADDR_W-1:0] ADDR_F_ASSIGN = ADDR_W'(IDX_F_ASSIGN * 4);
    // Field position of the optional pin on the first port
    localparam int BIT3_POS = 3;
    // Reset values of direction and pin-assign registers
    localparam logic [PORT_W-1:0] DIR_RESET = 8'h00;
    localparam logic [PORT_W-1:0] ASSIGN_RESET = 8'h00;
    // Bus response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: pin_sync.sv */
/*
 * Two-stage synchroniser for a group of pin inputs.
 * Assumes pins are asynchronous to aclk; only the second stage is read.
 */
`timescale 1ns/10ps
module pin_sync (
    input wire logic aclk,
    input wire logic [port_ef_pkg::PORT_W-1:0] async_in,
    output logic [port_ef_pkg::PORT_W-1:0] sync_out
);
    import port_ef_pkg::*;

    logic [PORT_W-1:0] meta_q; // First stage, read only by second stage

    // One pair of flops per pin
    for (genvar i = 0; i < PORT_W; i++) begin : g_bit
        always_ff @(posedge aclk) begin
            meta_q[i] <= async_in[i];
            sync_out[i] <= meta_q[i];
        end
    end
endmodule

/* File: port_ef_checker.sv */
/* Checker for the two-port data block: bus handshakes, read data shape and pin enables.
   Assumes it is bound to every instance of port_ef_data and sees only its ports. */
`timescale 1ns/10ps
module port_ef_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [port_ef_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [port_ef_pkg::PORT_W-1:0] first_port_oe,
    input wire logic [port_ef_pkg::PORT_W-1:0] first_port_pin_assign
);
    import port_ef_pkg::*;
    // One clock domain, reset quiets every check except reset_idle_a
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    read_gate_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("arready does not mirror rvalid");
    upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    write_order_a: assert property ($rose(s_axi_bvalid) |->
        $past(s_axi_awready) == 1'b0 && $past(s_axi_wready) == 1'b0)
        else $error("write response without address and data held");
    read_order_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
        else $error("read data without a read request");
    b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    err_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    alt_pin_a: assert property ((first_port_oe & first_port_pin_assign) == 8'h00)
        else $error("pin driven while given to alternate function");
    reset_idle_a: assert property (disable iff (1'b0) !aresetn |=>
        !s_axi_bvalid && !s_axi_rvalid && first_port_oe == 8'h00)
        else $error("bus or pin enables busy after reset");
endmodule
bind port_ef_data port_ef_checker port_ef_checker_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .first_port_oe(first_port_oe), .first_port_pin_assign(first_port_pin_assign));

/* File: port_pins.sv */
/* Far side of one 8-bit discrete port: each pin follows the block while enabled.
   Assumes no pulls; the bench sets the outside level of every undriven pin. */
`timescale 1ns/10ps
module port_pins (
    input wire logic [port_ef_pkg::PORT_W-1:0] ext_level,
    input wire logic [port_ef_pkg::PORT_W-1:0] pin_out,
    input wire logic [port_ef_pkg::PORT_W-1:0] pin_oe,
    output logic [port_ef_pkg::PORT_W-1:0] pin_in
);
    import port_ef_pkg::*;
    // Wire level: block value where enabled, outside source elsewhere
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule

/* File: tb_top.sv */
/* Bench for the two-port data block: AXI4-Lite tasks, pin models on one instance,
   and a second instance without the optional first-port bit3 on the same bus inputs.
   Assumes the package constants and a 200 MHz clock. */
`timescale 1ns/10ps
module tb_top;
    import port_ef_pkg::*;
    localparam int LIM = 200; // Bound on every handshake wait
    // Bus master side, outside pin levels and block outputs
    logic aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, sel = 1'b0;
    logic [7:0] awaddr = 8'h0, araddr = 8'h0, e_ext = 8'h30, f_ext = 8'h0;
    logic [7:0] e_in, f_in, e_out, e_oe, f_out, f_oe, e_pa, f_pa, e2_oe;
    logic [31:0] wdata = 32'h0, rdata, rdata2;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid;
    int mismatches = 0, n_tests = 0;
    // Full instance with pin models, second without bit3 and bus outputs mostly unused
    port_ef_data port_ef_data_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .first_port_in(e_in), .first_port_out(e_out), .first_port_oe(e_oe), .second_port_in(f_in),
        .second_port_out(f_out), .second_port_oe(f_oe), .first_port_pin_assign(e_pa),
        .second_port_pin_assign(f_pa));
    port_ef_data #(.BIT3_PRESENT(1'b0), .BIT3_READ_VALUE(1'b1)) port_ef_data_inst_nb (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
        .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(), .s_axi_rdata(rdata2), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
        .first_port_in(8'h00), .first_port_out(), .first_port_oe(e2_oe), .second_port_in(8'h00),
        .second_port_out(), .second_port_oe(), .first_port_pin_assign(), .second_port_pin_assign());
    port_pins port_pins_inst (.ext_level(e_ext), .pin_out(e_out), .pin_oe(e_oe), .pin_in(e_in));
    port_pins port_pins_inst_f (.ext_level(f_ext), .pin_out(f_out), .pin_oe(f_oe), .pin_in(f_in));
    // Free-running clock, 5 ns period
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // Verdict and end of run
    task automatic summarize;
        $display("Counts: %0d mismatches in %0d comparisons", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Compare seen against expected, four-state exact
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // A wait that ran out its bound ends the run
    task automatic guard(input int i);
        if (i >= LIM) begin
            chk(32'h0, 32'h1);
            summarize();
        end
    endtask
    // Write: address and data offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
        int i;
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (i = 0; i < LIM; i++) begin
            @(posedge aclk);
            // Each channel drops its valid at its own handshake edge
            if (!aw_done && awready) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
            if (aw_done && w_done) break;
        end
        guard(i);
        // Response accepted once both halves went over
        bready <= 1'b1;
        for (i = 0; i < LIM; i++) begin
            @(posedge aclk);
            if (bvalid) break;
        end
        guard(i);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    // Read: data of the selected instance and response checked
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int i;
        araddr <= a;
        arvalid <= 1'b1;
        for (i = 0; i < LIM; i++) begin
            @(posedge aclk);
            if (arready) break;
        end
        guard(i);
        arvalid <= 1'b0;
        rready <= 1'b1;
        for (i = 0; i < LIM; i++) begin
            @(posedge aclk);
            if (rvalid) break;
        end
        guard(i);
        rready <= 1'b0;
        chk(sel ? rdata2 : rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask
    // Main sequence
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ADDR_E_DIR, 32'h0, RESP_OKAY);
        rd(ADDR_F_ASSIGN, 32'h0, RESP_OKAY);
        wr(ADDR_E_DATA0, 32'ha5, 4'h1, RESP_OKAY);
        wr(ADDR_E_DIR, 32'h0f, 4'h1, RESP_OKAY);
        repeat (4) @(posedge aclk);
        rd(ADDR_E_DATA1, 32'h35, RESP_OKAY);
        chk({24'h0, e_out & e_oe}, 32'h05);
        wr(ADDR_E_ASSIGN, 32'h01, 4'h1, RESP_OKAY);
        wr(ADDR_E_DATA1, 32'hffffff5a, 4'h1, RESP_OKAY);
        e_ext <= 8'hc1;
        repeat (4) @(posedge aclk);
        rd(ADDR_E_DATA0, 32'hca, RESP_OKAY);
        chk({16'h0, e_pa, e_oe}, 32'h010e);
        wr(ADDR_E_DATA0, 32'h00, 4'h0, RESP_OKAY);
        rd(ADDR_E_DATA0, 32'hca, RESP_OKAY);
        wr(ADDR_F_DIR, 32'hff, 4'h1, RESP_OKAY);
        wr(ADDR_F_DATA1, 32'hffffff3c, 4'h1, RESP_OKAY);
        rd(ADDR_F_DATA0, 32'h3c, RESP_OKAY);
        chk({24'h0, f_out}, 32'h3c);
        chk({16'h0, f_pa, f_oe}, 32'h00ff);
        rd(8'h04, 32'h0, RESP_SLVERR);
        wr(8'h04, 32'h11, 4'h1, RESP_SLVERR);
        aresetn <= 1'b0;
        f_ext <= 8'h96;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({16'h0, e_out, f_out}, 32'h5a3c);
        rd(ADDR_E_DATA0, 32'hc1, RESP_OKAY);
        rd(ADDR_F_DATA1, 32'h96, RESP_OKAY);
        wr(ADDR_E_DIR, 32'hff, 4'h1, RESP_OKAY);
        chk({16'h0, e_oe, e2_oe}, 32'hfff7);
        wr(ADDR_E_DATA0, 32'h00, 4'h1, RESP_OKAY);
        rd(ADDR_E_DATA0, 32'h00, RESP_OKAY);
        sel = 1'b1;
        rd(ADDR_E_DATA0, 32'h08, RESP_OKAY);
        summarize();
    end
endmodule
